// File: shp_ctrl.sv
// shp_ctrl: two-wire slave, feature registers, status and field-paced converter
// assumes scl/sda and all pin levels are asynchronous; sda is open drain
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - six-bit converter fed from two analog inputs, mux alternates every field
// - each field flyback converts selected input into that input's result register
// - result update during a bus read clears its valid flag, else flag is 1
// - result code is linear from zero volts to half the reference
// - power up clears register_control_select, so pins drive features
// - slave address is acknowledged and served even in pin mode
// - select one takes features from registers, zero takes them from pins
// - noise control pin stays effective in both pin and bus mode
// - supply loss sets status bit 0, cleared only by reading status
// - status shows revision code in bits 3..1, bits 7..4 read zero
// - input registers written singly or in sequence, subaddress auto-increments
// - reads always start at output subaddress 0 and auto-increment
// - slave address 40h with strap low, e0h with strap high
// - luma_range_select picks 0.315 V at zero, 1.0 V at one
// - line_rate_select picks single rate at zero, double at one
// - contour_filter_select picks narrow filter at zero, wide at one
// - the four six-bit settings map linearly from 0% to 100%
// - results at output subaddresses 1 and 2: code, valid in bit 6
module shp_ctrl
	import shp_pkg::*;
#(
	parameter logic [2:0] REVISION = 3'h5  // arbitrary value
) (
	input  wire logic          mclk,
	input  wire logic          rstn,
	input  wire logic          scl_in,
	input  wire logic          sda_in,
	output logic               sda_out,
	output logic               sda_oe,
	input  wire logic          address_strap,
	input  wire logic          supply_loss_in,
	input  wire logic          field_flyback_in,
	input  wire logic          comparator_in,
	input  wire shp_features_t pin_features,
	input  wire logic [CODE_W-1:0] noise_control_input,
	output shp_features_t      features,
	output logic [CODE_W-1:0]  noise_level,
	output logic               analog_mux_select,
	output logic [CODE_W-1:0]  dac_trial_code
);

	// two-flop synchronisers; first stage is read only by the second
	logic [1:0]          scl_sync_q;
	logic [1:0]          sda_sync_q;
	logic [1:0]          strap_sync_q;
	logic [1:0]          loss_sync_q;
	logic [1:0]          fly_sync_q;
	logic [1:0]          cmp_sync_q;
	shp_features_t       pinf_meta_q;
	shp_features_t       pinf_q;
	logic [CODE_W-1:0]   noise_meta_q;
	logic [CODE_W-1:0]   noise_q;
	logic                scl_prev_q;
	logic                sda_prev_q;
	logic                fly_prev_q;

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			scl_sync_q   <= 2'h3;
			sda_sync_q   <= 2'h3;
			strap_sync_q <= 2'h0;
			loss_sync_q  <= 2'h0;
			fly_sync_q   <= 2'h0;
			cmp_sync_q   <= 2'h0;
			pinf_meta_q  <= '0;
			pinf_q       <= '0;
			noise_meta_q <= '0;
			noise_q      <= '0;
			scl_prev_q   <= 1'b1;
			sda_prev_q   <= 1'b1;
			fly_prev_q   <= 1'b0;
		end else begin
			scl_sync_q   <= {scl_sync_q[0], scl_in};
			sda_sync_q   <= {sda_sync_q[0], sda_in};
			strap_sync_q <= {strap_sync_q[0], address_strap};
			loss_sync_q  <= {loss_sync_q[0], supply_loss_in};
			fly_sync_q   <= {fly_sync_q[0], field_flyback_in};
			cmp_sync_q   <= {cmp_sync_q[0], comparator_in};
			pinf_meta_q  <= pin_features;
			pinf_q       <= pinf_meta_q;
			noise_meta_q <= noise_control_input;
			noise_q      <= noise_meta_q;
			scl_prev_q   <= scl_sync_q[1];
			sda_prev_q   <= sda_sync_q[1];
			fly_prev_q   <= fly_sync_q[1];
		end
	end

	// edges come from synchronised levels, so a glitch shorter than a clock is seen only if it spans an mclk edge
	wire scl_s     = scl_sync_q[1];
	wire sda_s     = sda_sync_q[1];
	wire scl_rise  = scl_s & ~scl_prev_q;
	wire scl_fall  = ~scl_s & scl_prev_q;
	wire bus_start = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
	wire bus_stop  = scl_s & scl_prev_q & ~sda_prev_q & sda_s;
	wire fly_edge  = fly_sync_q[1] & ~fly_prev_q;

	// strap level tracked continuously, so no reset-time capture is needed
	wire [6:0] own_addr = {strap_sync_q[1], ADDR_A5, strap_sync_q[1], ADDR_LOW};

	// register state
	logic [3:0]        mode_q;
	logic [CODE_W-1:0] peak_q;
	logic [CODE_W-1:0] steep_q;
	logic [CODE_W-1:0] coring_q;
	logic [CODE_W-1:0] aper_q;
	logic              loss_flag_q;
	shp_result_t       res_q [2];

	// bus engine state
	shp_bus_state_t    state_q;
	shp_bus_state_t    ack_next_q;
	logic [3:0]        bitcnt_q;
	logic [7:0]        shift_q;
	logic [7:0]        tx_q;
	logic [7:0]        sub_q;
	logic [7:0]        out_sub_q;
	logic              mack_q;

	// every source is an argument, so the load mux follows a result that lands mid-read
	function automatic logic [7:0] out_byte(
		input logic [7:0]  sub,
		input logic        loss,
		input shp_result_t r_one,
		input shp_result_t r_two
	);
		out_byte = 8'h00;
		case (sub)
			SUB_DEVICE_STATUS: out_byte = 8'(REVISION) << ST_REVISION_LSB | 8'(loss);
			SUB_RESULT_ONE:    out_byte = 8'(r_one.valid) << RES_VALID_BIT | 8'(r_one.code);
			SUB_RESULT_TWO:    out_byte = 8'(r_two.valid) << RES_VALID_BIT | 8'(r_two.code);
			default:           out_byte = 8'h00;
		endcase
	endfunction : out_byte

	wire       byte_in_done = scl_fall && (bitcnt_q == 4'h8);
	wire       addr_hit     = (shift_q[7:1] == own_addr);
	wire       addr_ack     = (state_q == ST_ADDR) && byte_in_done && addr_hit;
	wire       wr_strobe    = (state_q == ST_WR) && byte_in_done;
	wire       load_first   = (state_q == ST_ACK) && scl_fall && (ack_next_q == ST_RD);
	wire       load_next    = (state_q == ST_RACK) && scl_fall && mack_q;
	wire       load_byte    = load_first | load_next;
	wire [7:0] load_value   = out_byte(out_sub_q, loss_flag_q, res_q[0], res_q[1]);
	wire       status_read  = load_byte && (out_sub_q == SUB_DEVICE_STATUS);
	wire       read_active  = (state_q == ST_RD) || (state_q == ST_RACK)
		|| ((state_q == ST_ACK) && (ack_next_q == ST_RD));
	// saturating, so a long burst cannot wrap back onto mode_control
	wire [7:0] sub_inc      = (sub_q == SUB_MAX) ? sub_q : sub_q + 8'h01;

	// serial engine: sample on scl rise, drive on scl fall
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			state_q    <= ST_IDLE;
			ack_next_q <= ST_IDLE;
			bitcnt_q   <= 4'h0;
			shift_q    <= 8'h00;
			tx_q       <= 8'h00;
			sub_q      <= 8'h00;
			out_sub_q  <= 8'h00;
			mack_q     <= 1'b0;
			sda_oe     <= 1'b0;
			sda_out    <= 1'b0;
		end else if (bus_stop) begin
			state_q <= ST_IDLE;
			sda_oe  <= 1'b0;
		end else if (bus_start) begin
			state_q  <= ST_ADDR;
			bitcnt_q <= 4'h0;
			sda_oe   <= 1'b0;
		end else begin
			case (state_q)
				ST_ADDR, ST_SUB, ST_WR: begin
					if (scl_rise && bitcnt_q != 4'h8) begin
						shift_q  <= {shift_q[6:0], sda_s};
						bitcnt_q <= bitcnt_q + 4'h1;
					end else if (byte_in_done) begin
						bitcnt_q <= 4'h0;
						if (state_q == ST_ADDR && !addr_ack) begin
							state_q <= ST_IDLE;
						end else begin
							sda_oe  <= 1'b1;
							state_q <= ST_ACK;
						end
						if (state_q == ST_ADDR) begin
							ack_next_q <= shift_q[0] ? ST_RD : ST_SUB;
							out_sub_q  <= SUB_DEVICE_STATUS;
						end else if (state_q == ST_SUB) begin
							ack_next_q <= ST_WR;
							sub_q      <= shift_q;
						end else begin
							ack_next_q <= ST_WR;
							sub_q      <= sub_inc;
						end
					end
				end
				ST_ACK: begin
					if (scl_fall) begin
						state_q  <= ack_next_q;
						bitcnt_q <= 4'h0;
						sda_oe   <= load_first ? ~load_value[7] : 1'b0;
						if (load_first) begin
							tx_q      <= load_value;
							out_sub_q <= out_sub_q + 8'h01;
						end
					end
				end
				ST_RD: begin
					if (scl_fall) begin
						if (bitcnt_q == 4'h7) begin
							sda_oe  <= 1'b0;
							state_q <= ST_RACK;
						end else begin
							tx_q     <= {tx_q[6:0], 1'b0};
							sda_oe   <= ~tx_q[6];
							bitcnt_q <= bitcnt_q + 4'h1;
						end
					end
				end
				ST_RACK: begin
					if (scl_rise) begin
						mack_q <= ~sda_s;
					end else if (scl_fall) begin
						bitcnt_q <= 4'h0;
						if (mack_q) begin
							state_q   <= ST_RD;
							tx_q      <= load_value;
							sda_oe    <= ~load_value[7];
							out_sub_q <= (out_sub_q == SUB_MAX) ? out_sub_q : out_sub_q + 8'h01;
						end else begin
							state_q <= ST_IDLE;
						end
					end
				end
				default: begin
					sda_oe <= 1'b0;
				end
			endcase
		end
	end

	// input registers; upper byte bits are don't care and dropped
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			mode_q   <= MODE_CONTROL_RESET;
			peak_q   <= LEVEL_RESET;
			steep_q  <= LEVEL_RESET;
			coring_q <= LEVEL_RESET;
			aper_q   <= LEVEL_RESET;
		end else if (wr_strobe) begin
			case (sub_q)
				SUB_MODE_CONTROL: mode_q   <= shift_q[3:0];
				SUB_PEAKING:      peak_q   <= shift_q[CODE_W-1:0];
				SUB_STEEPNESS:    steep_q  <= shift_q[CODE_W-1:0];
				SUB_CORING:       coring_q <= shift_q[CODE_W-1:0];
				SUB_APERTURE:     aper_q   <= shift_q[CODE_W-1:0];
				default:          mode_q   <= mode_q;
			endcase
		end
	end

	// supply loss: reset itself counts as a loss; set beats the read clear
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			loss_flag_q <= SUPPLY_LOSS_RESET;
		end else if (loss_sync_q[1]) begin
			loss_flag_q <= 1'b1;
		end else if (status_read) begin
			loss_flag_q <= 1'b0;
		end
	end

	// feature selection; codes pass straight to the linear dacs
	shp_features_t bus_features;
	assign bus_features = '{
		contour_filter_select: mode_q[MC_CONTOUR_BIT],
		line_rate_select:      mode_q[MC_LINE_RATE_BIT],
		luma_range_select:     mode_q[MC_LUMA_RANGE_BIT],
		peaking_code:          peak_q,
		steepness_code:        steep_q,
		coring_code:           coring_q,
		line_width_code:       aper_q
	};

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			features    <= '0;
			noise_level <= '0;
		end else begin
			features    <= mode_q[MC_REG_SELECT_BIT] ? bus_features : pinf_q;
			noise_level <= noise_q;
		end
	end

	// converter sequencing: mux held steady through the conversion
	logic              sar_done;
	logic [CODE_W-1:0] sar_result;

	shp_sar #(
		.W      (CODE_W),
		.SETTLE (SAR_SETTLE_CYC)
	) u_sar (
		.mclk       (mclk),
		.rstn       (rstn),
		.start      (fly_edge),
		.cmp_above  (cmp_sync_q[1]),
		.trial_code (dac_trial_code),
		.done       (sar_done),
		.result     (sar_result)
	);

	// a result that lands mid-read is kept but flagged stale
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_res
			always_ff @(posedge mclk or negedge rstn) begin
				if (!rstn) begin
					res_q[gi] <= '{valid: RESULT_VALID_RESET, code: '0};
				end else if (sar_done && (analog_mux_select == 1'(gi))) begin
					res_q[gi] <= '{valid: ~read_active, code: sar_result};
				end
			end
		end
	endgenerate

	// toggle on completion, not on flyback, so each input gets a whole conversion
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			analog_mux_select <= 1'b0;
		end else if (sar_done) begin
			analog_mux_select <= ~analog_mux_select;
		end
	end

endmodule : shp_ctrl
`default_nettype wire

// File: shp_pkg.sv
// shp_pkg: constants and types for the sharpness control register block
// assumes a single 20 MHz clock domain; pin levels arrive asynchronously
package shp_pkg;

	// clock and timing
	localparam int CLK_PERIOD_NS   = 50;
	localparam int SAR_SETTLE_NS   = 1000;
	localparam int SAR_SETTLE_CYC  = (SAR_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CODE_W          = 6;

	// input subaddresses (write side)
	localparam logic [7:0] SUB_MODE_CONTROL   = 8'h00;
	localparam logic [7:0] SUB_PEAKING        = 8'h01;
	localparam logic [7:0] SUB_STEEPNESS      = 8'h02;
	localparam logic [7:0] SUB_CORING         = 8'h03;
	localparam logic [7:0] SUB_APERTURE       = 8'h04;
	localparam logic [7:0] SUB_LAST_INPUT     = 8'h04;
	localparam logic [7:0] SUB_MAX            = 8'hff;

	// output subaddresses (read side)
	localparam logic [7:0] SUB_DEVICE_STATUS  = 8'h00;
	localparam logic [7:0] SUB_RESULT_ONE     = 8'h01;
	localparam logic [7:0] SUB_RESULT_TWO     = 8'h02;

	// mode_control field positions
	localparam int MC_REG_SELECT_BIT = 0;
	localparam int MC_LUMA_RANGE_BIT = 1;
	localparam int MC_LINE_RATE_BIT  = 2;
	localparam int MC_CONTOUR_BIT    = 3;

	// device_status and result field positions
	localparam int ST_SUPPLY_LOSS_BIT = 0;
	localparam int ST_REVISION_LSB    = 1;
	localparam int RES_VALID_BIT      = 6;

	// reset values
	localparam logic [3:0]        MODE_CONTROL_RESET = 4'h0;
	localparam logic [CODE_W-1:0] LEVEL_RESET        = 6'h00;
	localparam logic              SUPPLY_LOSS_RESET  = 1'b1;
	localparam logic              RESULT_VALID_RESET = 1'b1;

	// slave address pieces: a6 and a4 follow the strap
	localparam logic       ADDR_A5     = 1'b1;
	localparam logic [3:0] ADDR_LOW    = 4'h0;

	typedef struct packed {
		logic              contour_filter_select;
		logic              line_rate_select;
		logic              luma_range_select;
		logic [CODE_W-1:0] peaking_code;
		logic [CODE_W-1:0] steepness_code;
		logic [CODE_W-1:0] coring_code;
		logic [CODE_W-1:0] line_width_code;
	} shp_features_t;

	typedef struct packed {
		logic              valid;
		logic [CODE_W-1:0] code;
	} shp_result_t;

	typedef enum {
		ST_IDLE,
		ST_ADDR,
		ST_SUB,
		ST_WR,
		ST_ACK,
		ST_RD,
		ST_RACK
	} shp_bus_state_t;

endpackage : shp_pkg

// File: shp_sar.sv
// shp_sar: successive-approximation sequencer for the 6-bit converter
// assumes cmp_above is already synchronised and means input above trial level
`timescale 1ns/1ps
`default_nettype none
module shp_sar
	import shp_pkg::*;
#(
	parameter int W      = CODE_W,
	parameter int SETTLE = SAR_SETTLE_CYC
) (
	input  wire logic         mclk,
	input  wire logic         rstn,
	input  wire logic         start,
	input  wire logic         cmp_above,
	output logic [W-1:0]      trial_code,
	output logic              done,
	output logic [W-1:0]      result
);
	localparam int CW = $clog2(SETTLE + 1);
	localparam int IW = $clog2(W + 1);

	logic          busy_q;
	logic [CW-1:0] wait_q;
	logic [IW-1:0] idx_q;
	wire           settled  = (wait_q == CW'(0));
	wire           last_bit = (idx_q == IW'(0));

	// trial code doubles as the dac drive so only one register holds it
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			busy_q     <= 1'b0;
			wait_q     <= '0;
			idx_q      <= '0;
			trial_code <= '0;
			done       <= 1'b0;
			result     <= '0;
		end else begin
			done <= 1'b0;
			if (start && !busy_q) begin
				busy_q     <= 1'b1;
				idx_q      <= IW'(W - 1);
				trial_code <= W'(1) << (W - 1);
				wait_q     <= CW'(SETTLE);
			end else if (busy_q && !settled) begin
				wait_q <= wait_q - CW'(1);
			end else if (busy_q) begin
				if (last_bit) begin
					busy_q <= 1'b0;
					done   <= 1'b1;
					result <= cmp_above ? trial_code : (trial_code & ~W'(1));
				end else begin
					trial_code <= (cmp_above ? trial_code : (trial_code & ~(W'(1) << idx_q)))
						| (W'(1) << (idx_q - IW'(1)));
					idx_q      <= idx_q - IW'(1);
					wait_q     <= CW'(SETTLE);
				end
			end
		end
	end

endmodule : shp_sar
`default_nettype wire

// File: shp_ctrl_properties.sv
// shp_ctrl_properties: port-level timing checks for shp_ctrl
// assumes one mclk domain, rstn asynchronous active low
`timescale 1ns/1ps
`default_nettype none
module shp_ctrl_properties
	import shp_pkg::*;
(
	input  wire logic              mclk,
	input  wire logic              rstn,
	input  wire logic              scl_in,
	input  wire logic              field_flyback_in,
	input  wire shp_features_t     pin_features,
	input  wire logic [CODE_W-1:0] noise_control_input,
	input  wire logic              sda_out,
	input  wire logic              sda_oe,
	input  wire shp_features_t     features,
	input  wire logic [CODE_W-1:0] noise_level,
	input  wire logic              analog_mux_select
);
	localparam int CONV_MIN = 120;
	localparam int CONV_MAX = 140;
	logic [7:0] fly_age_q;
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rstn);
	// cycles since the last flyback edge, saturating
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			fly_age_q <= 8'hff;
		end else if ($rose(field_flyback_in)) begin
			fly_age_q <= 8'h00;
		end else if (fly_age_q != 8'hff) begin
			fly_age_q <= fly_age_q + 8'h01;
		end
	end
	sda_out_low_a: assert property (sda_out == 1'b0)
		else $error("sda output not held low");
	reset_values_a: assert property ($rose(rstn) |-> features == '0 && noise_level == '0 && !analog_mux_select && !sda_oe)
		else $error("outputs not cleared by reset");
	noise_follow_a: assert property ($stable(noise_control_input)[*5] |-> noise_level == noise_control_input)
		else $error("noise level does not follow its pin");
	oe_scl_low_a: assert property ($changed(sda_oe) |-> !scl_in)
		else $error("sda drive changed while scl high");
	features_hold_a: assert property (($stable(pin_features) && scl_in)[*6] |-> $stable(features))
		else $error("features changed without a cause");
	conv_time_a: assert property ($rose(field_flyback_in) && fly_age_q > 8'd150 |-> ##[CONV_MIN:CONV_MAX] $changed(analog_mux_select))
		else $error("conversion did not finish in time");
	mux_cause_a: assert property ($changed(analog_mux_select) |-> fly_age_q >= CONV_MIN && fly_age_q <= CONV_MAX)
		else $error("mux toggled without a conversion");
	mux_once_a: assert property ($changed(analog_mux_select) |=> $stable(analog_mux_select)[*8])
		else $error("mux toggled twice");
endmodule : shp_ctrl_properties
bind shp_ctrl shp_ctrl_properties shp_ctrl_properties_inst (
	.mclk(mclk), .rstn(rstn), .scl_in(scl_in), .field_flyback_in(field_flyback_in),
	.pin_features(pin_features), .noise_control_input(noise_control_input), .sda_out(sda_out),
	.sda_oe(sda_oe), .features(features), .noise_level(noise_level), .analog_mux_select(analog_mux_select)
);
`default_nettype wire

// File: shp_host_model.sv
// shp_host_model: two-wire bus master for the control block
// assumes the bench resolves open-drain sda with a pull-up
`timescale 1ns/1ps
`default_nettype none
module shp_host_model (
	input  wire logic mclk,
	input  wire logic sda,
	output logic      scl,
	output logic      sda_low,
	output logic      rd_strobe,
	output logic [7:0] rd_byte
);
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
		rd_strobe = 1'b0;
		rd_byte = 8'h00;
	end
	// quarter bit of 4 mclk keeps scl at a sixteenth of mclk
	task automatic q;
		repeat (4) @(negedge mclk);
	endtask : q
	task automatic bit_io(input logic b, output logic s);
		q();
		sda_low = !b;
		q();
		scl = 1'b1;
		q();
		s = sda;
		q();
		scl = 1'b0;
	endtask : bit_io
	task automatic start;
		q();
		sda_low = 1'b1;
		q();
		scl = 1'b0;
	endtask : start
	task automatic stop;
		q();
		sda_low = 1'b1;
		q();
		scl = 1'b1;
		q();
		sda_low = 1'b0;
		q();
	endtask : stop
	task automatic wbyte(input logic [7:0] b, output logic ack);
		for (int i = 7; i >= 0; i--) begin
			bit_io(b[i], ack);
		end
		bit_io(1'b1, ack);
	endtask : wbyte
	task automatic rbyte(input logic last, output logic [7:0] b);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, b[i]);
		end
		bit_io(last, s);
		rd_byte = b;
		rd_strobe = 1'b1;
		@(negedge mclk);
		rd_strobe = 1'b0;
	endtask : rbyte
endmodule : shp_host_model
`default_nettype wire

// File: tb_top.sv
// tb_top: self-checking bench for shp_ctrl
// assumes shp_host_model as bus master; comparator modelled here
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import shp_pkg::*;
	localparam logic [2:0] REV = 3'h5; // arbitrary value
	logic              mclk = 1'b0;
	logic              rstn, scl, host_low, host_strobe, sda_out, sda_oe;
	logic              address_strap, supply_loss_in, field_flyback_in, comparator_in;
	logic [7:0]        host_byte;
	shp_features_t     pin_features, features, ef;
	logic [CODE_W-1:0] noise_control_input, noise_level, dac_trial_code, v1, v2;
	logic              analog_mux_select;
	logic [7:0]        exp_q[$];
	int                failures, comparisons;
	wire logic         sda = !(sda_oe || host_low);
	shp_ctrl #(.REVISION(REV)) shp_ctrl_inst (
		.mclk(mclk), .rstn(rstn), .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
		.address_strap(address_strap), .supply_loss_in(supply_loss_in), .field_flyback_in(field_flyback_in),
		.comparator_in(comparator_in), .pin_features(pin_features), .noise_control_input(noise_control_input),
		.features(features), .noise_level(noise_level), .analog_mux_select(analog_mux_select),
		.dac_trial_code(dac_trial_code));
	shp_host_model shp_host_model_inst (.mclk(mclk), .sda(sda), .scl(scl), .sda_low(host_low),
		.rd_strobe(host_strobe), .rd_byte(host_byte));
	always #25 mclk = ~mclk;
	// inputs sit half a code above v1/v2, so the ideal result equals them
	always @(negedge mclk) begin
		comparator_in <= (analog_mux_select ? v2 : v1) >= dac_trial_code;
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		comparisons++;
		if (seen !== want) begin
			failures++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask : check
	always @(posedge host_strobe) begin
		if (exp_q.size() == 0) begin
			failures++;
		end else begin
			check(32'(host_byte), 32'(exp_q.pop_front()));
		end
	end
	task automatic complete_run;
		if (exp_q.size() != 0) begin
			failures++;
		end
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : complete_run
	task automatic wr(input logic [7:0] adr, input logic want, input logic [7:0] d[]);
		logic a;
		shp_host_model_inst.start();
		shp_host_model_inst.wbyte(adr, a);
		check(32'(a), 32'(want));
		foreach (d[i]) begin
			shp_host_model_inst.wbyte(d[i], a);
		end
		shp_host_model_inst.stop();
		repeat (8) @(negedge mclk);
	endtask : wr
	task automatic rd(input logic [7:0] s0, input logic [7:0] r1, input logic [7:0] r2);
		logic a;
		logic [7:0] b;
		exp_q.push_back(s0);
		exp_q.push_back(r1);
		exp_q.push_back(r2);
		shp_host_model_inst.start();
		shp_host_model_inst.wbyte(8'h41, a);
		check(32'(a), 32'h0);
		repeat (2) shp_host_model_inst.rbyte(1'b0, b);
		shp_host_model_inst.rbyte(1'b1, b);
		shp_host_model_inst.stop();
	endtask : rd
	task automatic fly;
		field_flyback_in = 1'b1;
		repeat (10) @(negedge mclk);
		field_flyback_in = 1'b0;
	endtask : fly
	task automatic settle_check;
		repeat (8) @(negedge mclk);
		check(32'(features), 32'(ef));
	endtask : settle_check
	initial begin
		repeat (60000) @(posedge mclk);
		failures++;
		complete_run();
	end
	initial begin
		{rstn, address_strap, supply_loss_in, field_flyback_in} = 4'h0;
		pin_features = '0;
		noise_control_input = '0;
		v1 = 6'h3f;
		v2 = 6'h00;
		failures = 0;
		comparisons = 0;
		void'($urandom(32'h4841532b));
		repeat (4) @(negedge mclk);
		rstn = 1'b1;
		pin_features = shp_features_t'(27'($urandom()));
		noise_control_input = 6'($urandom());
		ef = pin_features;
		settle_check();
		check(32'(noise_level), 32'(noise_control_input));
		$display("test pin mode finished");
		repeat (2) begin
			fly();
			repeat (150) @(negedge mclk);
		end
		rd({4'h0, REV, 1'b1}, 8'h7f, 8'h40);
		supply_loss_in = 1'b1;
		repeat (4) @(negedge mclk);
		supply_loss_in = 1'b0;
		repeat (4) @(negedge mclk);
		rd({4'h0, REV, 1'b1}, 8'h7f, 8'h40);
		v1 = 6'($urandom());
		// result one lands after the address ack, before its byte is loaded
		fork
			rd({4'h0, REV, 1'b0}, {2'b00, v1}, 8'h40);
			begin
				repeat (120) @(negedge mclk);
				fly();
			end
		join
		$display("test converter and status finished");
		ef = shp_features_t'({3'b000, 24'($urandom())});
		wr(8'h40, 1'b0, '{8'h00, 8'hf1, {2'b11, ef.peaking_code}, {2'b10, ef.steepness_code},
			{2'b01, ef.coring_code}, {2'b11, ef.line_width_code}, 8'hff});
		pin_features = ~pin_features;
		settle_check();
		ef.coring_code = 6'($urandom());
		wr(8'h40, 1'b0, '{8'h03, {2'b00, ef.coring_code}});
		settle_check();
		noise_control_input = ~noise_control_input;
		repeat (8) @(negedge mclk);
		check(32'(noise_level), 32'(noise_control_input));
		for (int k = 0; k < 8; k++) begin
			{ef.contour_filter_select, ef.line_rate_select, ef.luma_range_select} = 3'(k);
			wr(8'h40, 1'b0, '{8'h00, {4'ha, 3'(k), 1'b1}});
			check(32'(features), 32'(ef));
		end
		address_strap = 1'b1;
		repeat (8) @(negedge mclk);
		wr(8'h40, 1'b1, '{8'h00, 8'h00});
		settle_check();
		wr(8'he0, 1'b0, '{8'h00, 8'h00});
		ef = pin_features;
		settle_check();
		$display("test bus mode finished");
		complete_run();
	end
endmodule : tb_top
`default_nettype wire
